// ### verilog/wts_defs.svh
// Offsets, field positions, reset values and counts of the weekly time switch
`ifndef WTS_DEFS_SVH
`define WTS_DEFS_SVH

// Structure of the switch bank
`define WTS_SWITCHES      8
`define WTS_CHANNELS      4
`define WTS_WORDS         32
`define WTS_LAST_IDX      5'h1F
`define WTS_FIRST_IDX     5'h00

// Register byte offsets
`define WTS_CHAN_BASE     8'h00
`define WTS_VIS_OFS       8'h80
`define WTS_STAT_OFS      8'h84
`define WTS_TIME_OFS      8'h88

// Address bit that splits channel words from control registers
`define WTS_CTRL_BIT      7

// Reset values
`define WTS_VIS_RST       8'hFF
`define WTS_WORD_RST      32'h00000000

// Time arithmetic
`define WTS_MIN_PER_HOUR  11'h03C
`define WTS_DAY_FIRST     3'h0
`define WTS_DAY_LAST      3'h6

// Status word fields
`define WTS_STAT_PWR_BIT  8
`define WTS_STAT_RUN_BIT  9

`endif

// ### verilog/wts_pkg.sv
// Types shared by the weekly time switch modules
package wts_pkg;

    // Weekday code, Monday first
    typedef enum logic [2:0] {
        DAY_MO = 3'h0,
        DAY_TU = 3'h1,
        DAY_WE = 3'h2,
        DAY_TH = 3'h3,
        DAY_FR = 3'h4,
        DAY_SA = 3'h5,
        DAY_SU = 3'h6
    } day_t;

    // One switching time; set low means unset
    typedef struct packed {
        logic       set;
        logic [4:0] hour;
        logic [5:0] minute;
    } sw_time_t;

    // One channel word as stored
    typedef struct packed {
        logic [1:0] spare;
        logic [2:0] end_day;
        logic [2:0] start_day;
        sw_time_t   off_time;
        sw_time_t   on_time;
    } chan_cfg_t;

    // Current time from the battery-backed clock
    typedef struct packed {
        logic [2:0] day;
        logic [4:0] hour;
        logic [5:0] minute;
    } rtc_time_t;

    // Scan sequencer states
    typedef enum logic [0:0] {
        S_OFF  = 1'b0,
        S_SCAN = 1'b1
    } scan_state_t;

endpackage

// ### verilog/wts_setting_mem.sv
// Channel setting store with one write port and two registered read ports
`timescale 1ns/1ps
`include "wts_defs.svh"
module wts_setting_mem (
    // Clock, reset, enable
    input  logic        core_clk,
    input  logic        rst,
    input  logic        ce,
    // Write port
    input  logic        wr_en,
    input  logic [4:0]  wr_idx,
    input  logic [31:0] wr_data,
    // Read port for the scanner
    input  logic [4:0]  a_idx,
    output logic [31:0] a_data,
    // Read port for the register bus
    input  logic [4:0]  b_idx,
    output logic [31:0] b_data
);
    import wts_pkg::*;

    logic [31:0] mem_q [`WTS_WORDS];  // Setting words

    // Reset clears all words so every time starts unset
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < `WTS_WORDS; i++)
            begin
                mem_q[i] <= `WTS_WORD_RST;
            end
            a_data <= `WTS_WORD_RST;
            b_data <= `WTS_WORD_RST;
        end
        else if (ce)
        begin
            if (wr_en)
            begin
                mem_q[wr_idx] <= wr_data;
            end
            a_data <= mem_q[a_idx];
            b_data <= mem_q[b_idx];
        end
    end
endmodule

// ### verilog/wts_channel_eval.sv
// Compares one channel's settings against the current weekday and time
`timescale 1ns/1ps
`include "wts_defs.svh"
module wts_channel_eval (
    // Channel settings and current time
    input  wts_pkg::chan_cfg_t cfg,
    input  wts_pkg::rtc_time_t now,
    // Results
    output logic               win,
    output logic               on_hit,
    output logic               off_hit
);
    import wts_pkg::*;

    // Minutes since midnight
    function automatic logic [10:0] to_min(input logic [4:0] h, input logic [5:0] m);
        to_min = {6'h00, h} * `WTS_MIN_PER_HOUR + {5'h00, m};
    endfunction

    // Span check, wrapping past Sunday when end precedes start
    function automatic logic in_span(input logic [2:0] d, input logic [2:0] s,
                                     input logic [2:0] e);
        if (s <= e)
            in_span = (d >= s) && (d <= e);
        else
            in_span = (d >= s) || (d <= e);
    endfunction

    logic [10:0] now_m;   // Current minute of day
    logic [10:0] on_m;    // On minute of day
    logic [10:0] off_m;   // Off minute of day
    logic [2:0]  prev_d;  // Day before today
    logic        today;   // Today inside span
    logic        yday;    // Yesterday inside span
    logic        late;    // Off falls on the next day

    // Window and edge detection
    always_comb
    begin
        now_m   = to_min(now.hour, now.minute);
        on_m    = to_min(cfg.on_time.hour, cfg.on_time.minute);
        off_m   = to_min(cfg.off_time.hour, cfg.off_time.minute);
        prev_d  = (now.day == `WTS_DAY_FIRST) ? `WTS_DAY_LAST : now.day - 3'h1;
        today   = in_span(now.day, cfg.start_day, cfg.end_day);
        yday    = in_span(prev_d, cfg.start_day, cfg.end_day);
        // Equal times mean a full day, midnight to midnight included
        late    = (off_m <= on_m);
        win     = 1'b0;
        // Only a channel with both times set forms a window
        if (cfg.on_time.set && cfg.off_time.set)
        begin
            if (late)
                win = (today && now_m >= on_m) || (yday && now_m < off_m);
            else
                win = today && now_m >= on_m && now_m < off_m;
        end
        on_hit  = cfg.on_time.set && today && (now_m == on_m);
        off_hit = cfg.off_time.set && (now_m == off_m) &&
                  ((cfg.on_time.set && late) ? yday : today);
    end
endmodule

// ### verilog/weekly_time_switch.sv
// Eight weekly time switches driving contacts from the real-time clock
// Summary of operation
// - Eight switches, each feeding one contact
// - Four channels per switch, A to D
// - Contact only, no coil input exists
// - Supply absent: contacts open, no switching
// - Channel holds start and end weekday
// - Times 00:00 to 23:59, unset never switches
// - Off before on switches off next day
// - Overlaps combine: any window or latched on closes, an on beats an off
// - Power-up recomputes contacts from all windows; lone on latches start open
// - Contact closed during any active window
// - Midnight to next midnight closes 24 hours
// - Per-switch menu visibility flag
// - Settings editable in run and stop
`timescale 1ns/1ps
`include "wts_defs.svh"
module weekly_time_switch (
    // Clock, reset, enable
    input  logic                core_clk,
    input  logic                rst,
    input  logic                ce,
    // Battery-backed clock and supply monitor
    input  wts_pkg::rtc_time_t  rtc_now,
    input  logic                power_good,
    // Register port
    input  logic [7:0]          addr,
    input  logic [31:0]         wdata,
    input  logic                wr,
    input  logic                rd,
    output logic [31:0]         rdata,
    // Contacts into the user circuit
    output logic [7:0]          weekly_switch_contacts,
    // Front-panel menu flags
    output logic [7:0]          menu_visible
);
    import wts_pkg::*;

    // Pin synchronisers
    rtc_time_t   rtc_s1_q;      // First stage, read by second only
    rtc_time_t   rtc_s1_d;
    rtc_time_t   rtc_s2_q;      // Second stage
    rtc_time_t   rtc_s2_d;
    rtc_time_t   rtc_s3_q;      // Stability sample
    rtc_time_t   rtc_s3_d;
    rtc_time_t   now_q;         // Settled current time
    rtc_time_t   now_d;
    logic        pwr_s1_q;      // First stage, read by second only
    logic        pwr_s1_d;
    logic        pwr_s2_q;      // Synchronised supply state
    logic        pwr_s2_d;

    // Scan sequencer
    scan_state_t state_q;       // Powered or not
    scan_state_t state_d;
    logic [4:0]  rd_idx_q;      // Word being fetched
    logic [4:0]  rd_idx_d;
    logic [4:0]  ev_idx_q;      // Word being evaluated
    logic [4:0]  ev_idx_d;
    logic        ev_vld_q;      // Fetched word is valid
    logic        ev_vld_d;
    rtc_time_t   scan_time_q;   // Time frozen for one pass
    rtc_time_t   scan_time_d;
    logic [7:0]  acc_win_q;     // Windows seen this pass
    logic [7:0]  acc_win_d;
    logic [7:0]  acc_on_q;      // Lone on times reached
    logic [7:0]  acc_on_d;
    logic [7:0]  acc_off_q;     // Off times reached
    logic [7:0]  acc_off_d;
    logic [7:0]  held_q;        // Contacts latched by lone on times
    logic [7:0]  held_d;
    logic [7:0]  contacts_q;    // Contact state
    logic [7:0]  contacts_d;

    // Register side
    logic [7:0]  vis_q;         // Menu visibility flags
    logic [7:0]  vis_d;
    logic        rd_vld_q;      // Read answer cycle
    logic        rd_vld_d;
    logic        rd_mem_q;      // Answer comes from the store
    logic        rd_mem_d;
    logic [31:0] rd_reg_q;      // Control register answer
    logic [31:0] rd_reg_d;

    // Combinational helpers
    logic [31:0] scan_word;     // Store output for the scanner
    logic [31:0] bus_word;      // Store output for the bus
    logic        mem_wr;        // Channel word write
    logic        ch_win;        // Evaluated channel inside window
    logic        ch_on;         // Evaluated lone on time reached
    logic        ch_off;        // Evaluated off time reached
    logic        ch_on_any;     // Any on time reached
    logic [7:0]  sw_mask;       // One-hot switch of evaluated word
    logic [7:0]  win_all;       // Windows including current word
    logic [7:0]  on_all;        // On times including current word
    logic [7:0]  off_all;       // Off times including current word
    logic [7:0]  held_n;        // Latch after a whole pass
    chan_cfg_t   scan_cfg;      // Fetched word as fields

    assign scan_cfg = chan_cfg_t'(scan_word);

    // Channel settings, one word per channel
    wts_setting_mem u_mem (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .wr_en    (mem_wr),
        .wr_idx   (addr[6:2]),
        .wr_data  (wdata),
        .a_idx    (rd_idx_q),
        .a_data   (scan_word),
        .b_idx    (addr[6:2]),
        .b_data   (bus_word)
    );

    // Single comparator shared over all channels in turn
    wts_channel_eval u_eval (
        .cfg     (scan_cfg),
        .now     (scan_time_q),
        .win     (ch_win),
        .on_hit  (ch_on_any),
        .off_hit (ch_off)
    );

    // A lone on time latches; a paired one is a window already
    assign ch_on = ch_on_any && !scan_cfg.off_time.set;

    // Synchroniser next values
    always_comb
    begin
        rtc_s1_d = rtc_now;
        rtc_s2_d = rtc_s1_q;
        rtc_s3_d = rtc_s2_q;
        pwr_s1_d = power_good;
        pwr_s2_d = pwr_s1_q;
        // Bus of bits may skew; take it only when two samples agree
        now_d    = (rtc_s2_q == rtc_s3_q) ? rtc_s2_q : now_q;
    end

    // Synchroniser registers
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rtc_s1_q <= '0;
            rtc_s2_q <= '0;
            rtc_s3_q <= '0;
            now_q    <= '0;
            pwr_s1_q <= 1'b0;
            pwr_s2_q <= 1'b0;
        end
        else if (ce)
        begin
            rtc_s1_q <= rtc_s1_d;
            rtc_s2_q <= rtc_s2_d;
            rtc_s3_q <= rtc_s3_d;
            now_q    <= now_d;
            pwr_s1_q <= pwr_s1_d;
            pwr_s2_q <= pwr_s2_d;
        end
    end

    // Scan sequencer next values
    always_comb
    begin
        state_d     = state_q;
        rd_idx_d    = rd_idx_q;
        ev_idx_d    = rd_idx_q;
        ev_vld_d    = 1'b0;
        scan_time_d = scan_time_q;
        acc_win_d   = acc_win_q;
        acc_on_d    = acc_on_q;
        acc_off_d   = acc_off_q;
        held_d      = held_q;
        contacts_d  = contacts_q;
        // Word index bits 4:2 name the switch, 1:0 the channel
        sw_mask     = 8'h01 << ev_idx_q[4:2];
        win_all     = acc_win_q | (ch_win ? sw_mask : 8'h00);
        on_all      = acc_on_q | (ch_on ? sw_mask : 8'h00);
        off_all     = acc_off_q | (ch_off ? sw_mask : 8'h00);
        // Channel order plays no part; an on beats a clear
        held_n      = on_all | (held_q & ~off_all);
        case (state_q)
            S_OFF:
            begin
                // Clock keeps running outside; contacts stay open
                contacts_d = 8'h00;
                held_d     = 8'h00;
                acc_win_d  = 8'h00;
                acc_on_d   = 8'h00;
                acc_off_d  = 8'h00;
                rd_idx_d   = `WTS_FIRST_IDX;
                if (pwr_s2_q)
                begin
                    // First full pass rebuilds every contact
                    state_d = S_SCAN;
                end
            end
            S_SCAN:
            begin
                ev_vld_d = 1'b1;
                rd_idx_d = rd_idx_q + 5'h01;
                if (rd_idx_q == `WTS_FIRST_IDX)
                begin
                    scan_time_d = now_q;
                end
                if (ev_vld_q)
                begin
                    acc_win_d = win_all;
                    acc_on_d  = on_all;
                    acc_off_d = off_all;
                    if (ev_idx_q == `WTS_LAST_IDX)
                    begin
                        // Pass complete: publish and start afresh
                        held_d     = held_n;
                        contacts_d = win_all | held_n;
                        acc_win_d  = 8'h00;
                        acc_on_d   = 8'h00;
                        acc_off_d  = 8'h00;
                    end
                end
                if (!pwr_s2_q)
                begin
                    // Supply lost: drop contacts at once
                    state_d    = S_OFF;
                    contacts_d = 8'h00;
                    held_d     = 8'h00;
                end
            end
            default:
            begin
                state_d = S_OFF;
            end
        endcase
    end

    // Scan sequencer registers
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_q     <= S_OFF;
            rd_idx_q    <= `WTS_FIRST_IDX;
            ev_idx_q    <= `WTS_FIRST_IDX;
            ev_vld_q    <= 1'b0;
            scan_time_q <= '0;
            acc_win_q   <= 8'h00;
            acc_on_q    <= 8'h00;
            acc_off_q   <= 8'h00;
            held_q      <= 8'h00;
            contacts_q  <= 8'h00;
        end
        else if (ce)
        begin
            state_q     <= state_d;
            rd_idx_q    <= rd_idx_d;
            ev_idx_q    <= ev_idx_d;
            ev_vld_q    <= ev_vld_d;
            scan_time_q <= scan_time_d;
            acc_win_q   <= acc_win_d;
            acc_on_q    <= acc_on_d;
            acc_off_q   <= acc_off_d;
            held_q      <= held_d;
            contacts_q  <= contacts_d;
        end
    end

    // Channel words sit below the control block
    assign mem_wr = wr && !addr[`WTS_CTRL_BIT];

    // Register port next values
    always_comb
    begin
        vis_d    = vis_q;
        rd_vld_d = rd;
        rd_mem_d = rd && !addr[`WTS_CTRL_BIT];
        rd_reg_d = 32'h00000000;
        // Writes are taken in any operating mode
        if (wr && addr == `WTS_VIS_OFS)
        begin
            vis_d = wdata[7:0];
        end
        if (rd)
        begin
            case (addr)
                `WTS_VIS_OFS:
                begin
                    rd_reg_d = {24'h000000, vis_q};
                end
                `WTS_STAT_OFS:
                begin
                    rd_reg_d[7:0]               = contacts_q;
                    rd_reg_d[`WTS_STAT_PWR_BIT] = pwr_s2_q;
                    rd_reg_d[`WTS_STAT_RUN_BIT] = (state_q == S_SCAN);
                end
                `WTS_TIME_OFS:
                begin
                    rd_reg_d = {18'h00000, now_q};
                end
                default:
                begin
                    // Unmapped and channel reads give zero here
                    rd_reg_d = 32'h00000000;
                end
            endcase
        end
    end

    // Register port registers
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            vis_q    <= `WTS_VIS_RST;
            rd_vld_q <= 1'b0;
            rd_mem_q <= 1'b0;
            rd_reg_q <= 32'h00000000;
        end
        else if (ce)
        begin
            vis_q    <= vis_d;
            rd_vld_q <= rd_vld_d;
            rd_mem_q <= rd_mem_d;
            rd_reg_q <= rd_reg_d;
        end
    end

    // Answer only in the cycle after the strobe
    assign rdata = !rd_vld_q ? 32'h00000000 : (rd_mem_q ? bus_word : rd_reg_q);

    // Contacts follow the clock alone; the circuit cannot drive them
    assign weekly_switch_contacts = contacts_q;
    assign menu_visible           = vis_q;

endmodule

// ### tb/weekly_time_switch_props.sv
// Checker of the weekly time switch port behaviour
`timescale 1ns/1ps
module weekly_time_switch_props (
    // Clock, reset, enable
    input  logic               core_clk,
    input  logic               rst,
    input  logic               ce,
    // Clock and supply monitor
    input  wts_pkg::rtc_time_t rtc_now,
    input  logic               power_good,
    // Register port
    input  logic [7:0]         addr,
    input  logic [31:0]        wdata,
    input  logic               wr,
    input  logic               rd,
    input  logic [31:0]        rdata,
    // Contacts and menu flags
    input  logic [7:0]         weekly_switch_contacts,
    input  logic [7:0]         menu_visible
);
    import wts_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [7:0] wlow;                 // Low byte of write data, for the menu flags
    assign wlow = wdata[7:0];

    // Bus answers stand one cycle only
    rdata_idle_a: assert property (ce && !rd |=> rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    reset_state_a: assert property ($fell(rst) |-> menu_visible == 8'hFF
        && weekly_switch_contacts == 8'h00) else $error("bad state after reset");
    pwr_loss_a: assert property (!power_good [*4] |-> weekly_switch_contacts == 8'h00)
        else $error("contact closed without supply");
    pwr_needed_a: assert property (weekly_switch_contacts != 8'h00 |->
        $past(power_good, 4) && $past(power_good, 30)) else $error("contact before power-up scan");
    // Contacts move once per pass, except the drop on power loss
    contact_hold_a: assert property (!$stable(weekly_switch_contacts)
        && weekly_switch_contacts != 8'h00 |=> ($stable(weekly_switch_contacts)
        || weekly_switch_contacts == 8'h00) [*8]) else $error("contacts changed inside a pass");
    word_readback_a: assert property (wr && ce && addr < 8'h80 ##1 rd && ce
        && addr == $past(addr) |=> rdata == $past(wdata, 2)) else $error("word readback wrong");
    vis_write_a: assert property (wr && ce && addr == 8'h80 |=>
        menu_visible == $past(wlow)) else $error("menu flags not updated");
    stat_read_a: assert property (rd && ce && addr == 8'h84 |=>
        rdata[7:0] == $past(weekly_switch_contacts)) else $error("status contacts wrong");
    hole_read_a: assert property (rd && ce && addr > 8'h8B |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    cover property (wr ##1 rd);
    cover property ($fell(power_good));
    cover property (weekly_switch_contacts == 8'h41);
endmodule

bind weekly_time_switch weekly_time_switch_props weekly_time_switch_props_inst (
    .core_clk(core_clk), .rst(rst), .ce(ce), .rtc_now(rtc_now), .power_good(power_good),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .weekly_switch_contacts(weekly_switch_contacts), .menu_visible(menu_visible));

// ### tb/rtc_model.sv
// Battery-backed clock and supply monitor that feed the switch bank
`timescale 1ns/1ps
module rtc_model (
    // Clock
    input  logic               core_clk,
    // Towards the switch bank
    output wts_pkg::rtc_time_t rtc_now,
    output logic               power_good
);
    import wts_pkg::*;
    // Supply starts absent; time is kept across outages
    initial
    begin
        rtc_now = '0;
        power_good = 1'b0;
    end
    // New time lands just after an edge, all fields together
    task automatic set_time(input logic [2:0] d, input logic [4:0] h, input logic [5:0] m);
        @(posedge core_clk);
        rtc_now <= '{day: d, hour: h, minute: m};
    endtask
    // Supply monitor level
    task automatic set_power(input logic on);
        @(posedge core_clk);
        power_good <= on;
    endtask
endmodule

// ### tb/weekly_time_switch_test.sv
// Directed bench for the weekly time switch
`timescale 1ns/1ps
module weekly_time_switch_test;
    import wts_pkg::*;
    logic        core_clk;       // Bench clock
    logic        rst;            // Synchronous reset
    logic        ce;             // Run enable
    logic        power_good;     // Supply from the partner
    logic        wr;             // Write strobe
    logic        rd;             // Read strobe
    logic [7:0]  addr;           // Byte address
    logic [7:0]  contacts;       // Switch contacts
    logic [7:0]  vis;            // Menu flags
    logic [31:0] wdata;          // Write data
    logic [31:0] rdata;          // Read data
    logic [31:0] v;              // Last value read
    rtc_time_t   rtc_now;        // Clock from the partner
    int          num_errors;
    int          comparisons;
    int          i;

    // Free-running core clock
    always #5 core_clk = ~core_clk;

    rtc_model partner_inst (.core_clk(core_clk), .rtc_now(rtc_now), .power_good(power_good));
    weekly_time_switch weekly_time_switch_inst (
        .core_clk(core_clk), .rst(rst), .ce(ce), .rtc_now(rtc_now), .power_good(power_good),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .weekly_switch_contacts(contacts), .menu_visible(vis));

    // Verdict and end of run
    task close_out;
        if (num_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One comparison
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // Bus cycles; strobes stay up so back-to-back calls need no gap
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        rd <= 1'b0;
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
    endtask
    task rd_reg(input logic [7:0] a);
        wr <= 1'b0;
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        #1 v = rdata;
    endtask
    task settle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask
    // Set the time, let two passes run, then compare contacts
    task step(input logic [2:0] d, input logic [4:0] h, input logic [5:0] m,
              input logic [7:0] e);
        partner_inst.set_time(d, h, m);
        settle(90);
        #1 check("contacts", {24'h0, e}, {24'h0, contacts});
    endtask
    function automatic logic [11:0] tm(input logic [4:0] h, input logic [5:0] m);
        return {1'b1, h, m};
    endfunction
    function automatic logic [31:0] chw(input logic [2:0] s, input logic [2:0] e,
                                        input logic [11:0] t_on, input logic [11:0] t_off);
        return {2'h0, e, s, t_off, t_on};
    endfunction

    // Hang guard
    initial
    begin
        repeat (100000) @(posedge core_clk);
        num_errors++;
        close_out;
    end

    // Main sequence
    initial
    begin
        core_clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        num_errors = 0;
        comparisons = 0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        #1 check("menu_visible", 32'hFF, {24'h0, vis});
        for (i = 0; i < 32; i++)
        begin
            rd_reg(8'(4 * i));
            check("reset word", 32'h0, v);
        end
        for (i = 0; i < 32; i++)
        begin
            wr_reg(8'(4 * i), 32'hA5C30000 + 32'(i));
            rd_reg(8'(4 * i));
            check("word", 32'hA5C30000 + 32'(i), v);
        end
        for (i = 0; i < 32; i++)
            wr_reg(8'(4 * i), 32'h0);
        rd_reg(8'h90);
        check("unmapped", 32'h0, v);
        wr_reg(8'h80, 32'h5A);
        rd_reg(8'h80);
        check("vis reg", 32'h5A, v & 32'hFF);
        check("menu_visible", 32'h5A, {24'h0, vis});
        // Frozen core must ignore a write
        ce <= 1'b0;
        wr_reg(8'h80, 32'h33);
        ce <= 1'b1;
        rd_reg(8'h80);
        check("frozen vis", 32'h5A, {24'h0, vis});
        wr_reg(8'h00, chw(DAY_MO, DAY_FR, tm(5'h06, 6'h1E), tm(5'h09, 6'h00)));
        wr_reg(8'h04, chw(DAY_MO, DAY_FR, tm(5'h11, 6'h00), tm(5'h16, 6'h1E)));
        wr_reg(8'h10, chw(DAY_FR, DAY_MO, tm(5'h08, 6'h00), tm(5'h0C, 6'h00)));
        wr_reg(8'h20, chw(DAY_MO, DAY_MO, tm(5'h16, 6'h00), tm(5'h06, 6'h00)));
        wr_reg(8'h30, chw(DAY_MO, DAY_MO, tm(5'h10, 6'h00), tm(5'h16, 6'h00)));
        wr_reg(8'h34, chw(DAY_TU, DAY_WE, tm(5'h0A, 6'h00), tm(5'h16, 6'h00)));
        wr_reg(8'h40, chw(DAY_MO, DAY_MO, tm(5'h00, 6'h00), tm(5'h00, 6'h00)));
        wr_reg(8'h50, chw(DAY_MO, DAY_SU, tm(5'h0A, 6'h00), 12'h000));
        wr_reg(8'h54, chw(DAY_MO, DAY_SU, 12'h000, tm(5'h0C, 6'h00)));
        wr_reg(8'h60, chw(DAY_MO, DAY_SU, 12'h000, 12'h000));
        step(DAY_MO, 5'h07, 6'h00, 8'h00);
        partner_inst.set_power(1'b1);
        step(DAY_MO, 5'h07, 6'h00, 8'h11);
        step(DAY_MO, 5'h0A, 6'h00, 8'h32);
        step(DAY_MO, 5'h0B, 6'h00, 8'h32);
        step(DAY_MO, 5'h0C, 6'h00, 8'h10);
        step(DAY_MO, 5'h17, 6'h00, 8'h14);
        step(DAY_TU, 5'h03, 6'h00, 8'h04);
        step(DAY_TU, 5'h0B, 6'h00, 8'h08);
        step(DAY_WE, 5'h0A, 6'h00, 8'h28);
        step(DAY_SU, 5'h0A, 6'h00, 8'h22);
        step(DAY_FR, 5'h12, 6'h00, 8'h21);
        rd_reg(8'h84);
        check("status", 32'h321, v & 32'h3FF);
        rd_reg(8'h88);
        check("time", {18'h0, DAY_FR, 5'h12, 6'h00}, v & 32'h3FFF);
        partner_inst.set_power(1'b0);
        settle(6);
        check("contacts", 32'h0, {24'h0, contacts});
        step(DAY_FR, 5'h17, 6'h00, 8'h00);
        partner_inst.set_power(1'b1);
        step(DAY_FR, 5'h17, 6'h00, 8'h00);
        partner_inst.set_power(1'b0);
        step(DAY_FR, 5'h14, 6'h00, 8'h00);
        partner_inst.set_power(1'b1);
        step(DAY_FR, 5'h14, 6'h00, 8'h01);
        wr_reg(8'h60, chw(DAY_MO, DAY_SU, tm(5'h00, 6'h00), tm(5'h17, 6'h3B)));
        step(DAY_FR, 5'h14, 6'h00, 8'h41);
        close_out;
    end
endmodule
